// ==== hw/csh_pkg.sv ====
package csh_pkg;
    localparam int SYS_HZ = 20000000;
    localparam int SCLK_MAX_HZ = 3000000;
    // slower than the limit: both ends add three sync flops to each pin
    localparam int SCLK_HZ = 1000000;
    localparam int SCLK_HALF_CYC = SYS_HZ / (2 * SCLK_HZ);
    localparam int UPDATE_HZ = 50;
    localparam int CONV_CYC = SYS_HZ / UPDATE_HZ;
    localparam int READY_LEAD_CYC = 20;
    localparam int RESET_ONES = 32;
    localparam int COMM_BITS = 8;

    localparam int COMM_WEN_BIT = 7;
    localparam int COMM_RW_BIT = 3;
    localparam int COMM_STBY_BIT = 2;
    localparam int SETUP_FSYNC_BIT = 0;
    localparam int CLOCK_HALVE_BIT = 3;

    localparam logic [2:0] RS_COMM = 3'h0;
    localparam logic [2:0] RS_SETUP = 3'h1;
    localparam logic [2:0] RS_CLOCK = 3'h2;
    localparam logic [2:0] RS_DATA = 3'h3;
    localparam logic [2:0] RS_TEST = 3'h4;
    localparam logic [2:0] RS_ZERO = 3'h6;
    localparam logic [2:0] RS_FULL = 3'h7;

    localparam logic [7:0] COMM_RST = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h01;
    localparam logic [7:0] CLOCK_RST = 8'h05;
    localparam logic [7:0] TEST_RST = 8'h00;
    localparam logic [23:0] ZERO_RST = 24'h1f4000;
    localparam logic [23:0] FULL_RST = 24'h5761ab;

    localparam logic [7:0] CMD_TO_CLOCK = 8'h20;
    localparam logic [7:0] CLOCK_WORD = 8'h0c;
    localparam logic [7:0] CMD_TO_SETUP = 8'h10;
    localparam logic [7:0] SETUP_WORD = 8'h40;
    localparam logic [7:0] CMD_READ_DATA = 8'h38;

    localparam logic [4:0] HR_CTRL = 5'h00;
    localparam logic [4:0] HR_COUNT = 5'h04;
    localparam logic [4:0] HR_STATUS = 5'h08;
    localparam logic [4:0] HR_DATA = 5'h0c;
    localparam logic [4:0] HR_IRQ = 5'h10;
    localparam logic [4:0] HR_MASK = 5'h14;
    localparam int CTRL_START = 0;
    localparam int CTRL_RESET = 1;

    typedef enum logic [2:0] {D_CMD = 3'b001, D_WR = 3'b010, D_RD = 3'b100} csh_dst_t;
    typedef enum logic [2:0] {H_IDLE = 3'b001, H_SHIFT = 3'b010, H_WAIT = 3'b100} csh_hst_t;

    function automatic logic [5:0] csh_reg_len(input logic [2:0] rs);
        case (rs)
            RS_DATA: csh_reg_len = 6'h10;
            RS_ZERO, RS_FULL: csh_reg_len = 6'h18;
            default: csh_reg_len = 6'h08;
        endcase
    endfunction
endpackage

// ==== hw/csh_if.sv ====
interface csh_if;
    logic sclk;
    logic din;
    logic cs_n;
    logic dout;
    logic dout_oe;
    logic result_ready_n;
    // undriven output line is pulled up
    wire miso = dout_oe ? dout : 1'b1;

    modport dev (
        input sclk,
        input din,
        input cs_n,
        output dout,
        output dout_oe,
        output result_ready_n
    );
    modport host (
        output sclk,
        output din,
        output cs_n,
        input miso,
        input result_ready_n
    );
endinterface

// ==== hw/csh_dev.sv ====
module csh_dev #(
    parameter int CONV_CYC = csh_pkg::CONV_CYC,
    parameter int LEAD_CYC = csh_pkg::READY_LEAD_CYC
) (
    input logic sys_clk,
    input logic rst,
    csh_if.dev link,
    input logic [15:0] conv_word,
    output logic conv_take,
    output logic cal_start,
    output logic [7:0] setup_q,
    output logic [7:0] clock_q,
    output logic [1:0] chan_q
);
    localparam int CW = $clog2(CONV_CYC);

    // pin order {sclk, din, cs_n}
    logic [2:0] s0_r;
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] pin_r;
    csh_pkg::csh_dst_t st_r;
    logic [23:0] sh_r;
    logic [5:0] cnt_r;
    logic [5:0] len_r;
    logic [2:0] rs_r;
    logic [5:0] ones_r;
    logic [7:0] comm_r;
    logic [7:0] setup_r;
    logic [7:0] clock_r;
    logic [7:0] test_r;
    logic [23:0] zero_r;
    logic [23:0] full_r;
    logic [15:0] data_r;
    logic dout_r;
    logic oe_r;
    logic rdy_n_r;
    logic [CW-1:0] conv_r;
    logic take_r;
    logic cal_r;

    wire [2:0] pins = {link.sclk, link.din, link.cs_n};
    wire [2:0] agree = ~(s1_r ^ s2_r);
    wire [2:0] pin_nxt = (agree & s2_r) | (~agree & pin_r);
    wire sel = ~pin_nxt[0];
    wire rise = sel & pin_nxt[2] & ~pin_r[2];
    wire fall = sel & ~pin_nxt[2] & pin_r[2];
    wire bit_in = pin_nxt[1];

    wire last = (cnt_r == (len_r - 6'h01));
    wire [23:0] shifted = {sh_r[22:0], bit_in};
    wire [7:0] cmd_byte = shifted[7:0];
    wire [2:0] cmd_rs = cmd_byte[6:4];
    wire cmd_read = cmd_byte[csh_pkg::COMM_RW_BIT];
    wire [5:0] cmd_len = csh_pkg::csh_reg_len(cmd_rs);
    wire cmd_done = (st_r == csh_pkg::D_CMD) & (cnt_r == 6'(csh_pkg::COMM_BITS - 1));
    // a command byte starts only with a zero, so idle ones are skipped
    wire wen_skip = (st_r == csh_pkg::D_CMD) & (cnt_r == 6'h00) & bit_in;
    wire reading = (st_r == csh_pkg::D_RD);
    wire ones_hit = bit_in & ~reading & (ones_r == 6'(csh_pkg::RESET_ONES - 1));
    wire [5:0] shamt = 6'h18 - cmd_len;
    wire [23:0] comm_rd = {16'h0000, rdy_n_r, comm_r[6:0]};
    wire [23:0] rd_word =
        (cmd_rs == csh_pkg::RS_COMM) ? comm_rd :
        (cmd_rs == csh_pkg::RS_SETUP) ? {16'h0000, setup_r} :
        (cmd_rs == csh_pkg::RS_CLOCK) ? {16'h0000, clock_r} :
        (cmd_rs == csh_pkg::RS_DATA) ? {8'h00, data_r} :
        (cmd_rs == csh_pkg::RS_TEST) ? {16'h0000, test_r} :
        (cmd_rs == csh_pkg::RS_ZERO) ? zero_r :
        (cmd_rs == csh_pkg::RS_FULL) ? full_r : 24'h000000;
    wire [23:0] rd_align = rd_word << shamt;

    wire wr_commit = rise & ~ones_hit & (st_r == csh_pkg::D_WR) & last;
    wire setup_wr = wr_commit & (rs_r == csh_pkg::RS_SETUP);
    // any non-zero mode field starts a calibration cycle
    wire cal_go = setup_wr & (shifted[7:6] != 2'h0);
    wire read_done = rise & reading & last & (rs_r == csh_pkg::RS_DATA);
    wire run = ~setup_r[csh_pkg::SETUP_FSYNC_BIT] & ~comm_r[csh_pkg::COMM_STBY_BIT];
    wire upd = run & (conv_r == CW'(CONV_CYC - 1));
    wire lead = run & (conv_r == CW'(CONV_CYC - 1 - LEAD_CYC));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s0_r <= 3'h7;
            s1_r <= 3'h7;
            s2_r <= 3'h7;
            pin_r <= 3'h7;
        end else begin
            s0_r <= pins;
            s1_r <= s0_r;
            s2_r <= s1_r;
            pin_r <= pin_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ones_r <= 6'h00;
        end else if (rise) begin
            // read phases do not count, the input is not looked at then
            ones_r <= (bit_in & ~reading & ~ones_hit) ? ones_r + 6'h01 : 6'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= csh_pkg::D_CMD;
            sh_r <= 24'h000000;
            cnt_r <= 6'h00;
            len_r <= 6'(csh_pkg::COMM_BITS);
            rs_r <= csh_pkg::RS_COMM;
            comm_r <= csh_pkg::COMM_RST;
        end else if (rise) begin
            if (ones_hit) begin
                st_r <= csh_pkg::D_CMD;
                cnt_r <= 6'h00;
            end else begin
                unique case (st_r)
                    csh_pkg::D_CMD: begin
                        if (cmd_done) begin
                            comm_r <= cmd_byte;
                            rs_r <= cmd_rs;
                            len_r <= cmd_len;
                            cnt_r <= 6'h00;
                            sh_r <= rd_align;
                            // next edge already belongs to the target access
                            if (cmd_read) begin
                                st_r <= csh_pkg::D_RD;
                            end else if (cmd_rs != csh_pkg::RS_COMM) begin
                                st_r <= csh_pkg::D_WR;
                            end
                        end else if (!wen_skip) begin
                            sh_r <= shifted;
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end
                    csh_pkg::D_WR: begin
                        sh_r <= shifted;
                        cnt_r <= last ? 6'h00 : cnt_r + 6'h01;
                        if (last) begin
                            st_r <= csh_pkg::D_CMD;
                        end
                    end
                    csh_pkg::D_RD: begin
                        sh_r <= {sh_r[22:0], 1'b0};
                        cnt_r <= last ? 6'h00 : cnt_r + 6'h01;
                        if (last) begin
                            st_r <= csh_pkg::D_CMD;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            setup_r <= csh_pkg::SETUP_RST;
            clock_r <= csh_pkg::CLOCK_RST;
            test_r <= csh_pkg::TEST_RST;
            zero_r <= csh_pkg::ZERO_RST;
            full_r <= csh_pkg::FULL_RST;
        end else if (wr_commit) begin
            unique case (rs_r)
                csh_pkg::RS_SETUP: setup_r <= shifted[7:0];
                csh_pkg::RS_CLOCK: clock_r <= shifted[7:0];
                csh_pkg::RS_TEST: test_r <= shifted[7:0];
                csh_pkg::RS_ZERO: zero_r <= shifted;
                csh_pkg::RS_FULL: full_r <= shifted;
                default: ; // data and unused selects are read only
            endcase
        end
    end

    // the filter model is only a period counter; the halving bit and
    // rate field are exported, the period itself is a parameter
    always_ff @(posedge sys_clk) begin
        if (rst || cal_go || !run) begin
            conv_r <= '0;
        end else begin
            conv_r <= upd ? '0 : conv_r + CW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdy_n_r <= 1'b1;
            data_r <= 16'h0000;
        end else if (upd) begin
            // a fresh result wins over a read completing in the same cycle
            rdy_n_r <= 1'b0;
            data_r <= conv_word;
        end else if (lead || read_done || cal_go) begin
            rdy_n_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dout_r <= 1'b1;
            oe_r <= 1'b0;
            take_r <= 1'b0;
            cal_r <= 1'b0;
        end else begin
            if (fall && reading) begin
                dout_r <= sh_r[23];
            end
            oe_r <= reading & ~pin_r[0];
            take_r <= upd;
            cal_r <= cal_go;
        end
    end

    assign link.dout = dout_r;
    assign link.dout_oe = oe_r;
    assign link.result_ready_n = rdy_n_r;
    assign conv_take = take_r;
    assign cal_start = cal_r;
    assign setup_q = setup_r;
    assign clock_q = clock_r;
    assign chan_q = comm_r[1:0];
endmodule

// ==== hw/csh_host.sv ====
module csh_host #(
    parameter int HALF_CYC = csh_pkg::SCLK_HALF_CYC
) (
    input logic sys_clk,
    input logic rst,
    input logic [4:0] addr,
    input logic [31:0] wdata,
    input logic wr,
    input logic rd,
    output logic [31:0] rdata,
    output logic irq,
    csh_if.host link
);
    // pin order {miso, result_ready_n}
    logic [1:0] s0_r;
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] pin_r;
    csh_pkg::csh_hst_t st_r;
    logic [2:0] step_r;
    logic [31:0] tx_r;
    logic [15:0] rx_r;
    logic [5:0] len_r;
    logic [5:0] bit_r;
    logic [7:0] div_r;
    logic ph_r;
    logic rdx_r;
    logic sclk_r;
    logic mosi_r;
    logic cs_n_r;
    logic [15:0] tgt_r;
    logic [15:0] done_r;
    logic [15:0] data_r;
    logic [1:0] irq_st_r;
    logic [1:0] mask_r;
    logic irq_r;
    logic rdy_seen_r;
    logic [31:0] rdata_r;

    wire [1:0] agree = ~(s1_r ^ s2_r);
    wire [1:0] pin_nxt = (agree & s2_r) | (~agree & pin_r);
    wire miso = pin_r[1];
    wire ready = ~pin_r[0];
    wire shifting = (st_r == csh_pkg::H_SHIFT);
    wire tick = shifting & (div_r == 8'(HALF_CYC - 1));
    wire last = tick & ph_r & (bit_r == (len_r - 6'h01));
    wire [15:0] rx_nxt = {rx_r[14:0], miso};
    wire ctrl_wr = wr & (addr == csh_pkg::HR_CTRL) & (st_r == csh_pkg::H_IDLE);
    wire start = ctrl_wr & wdata[csh_pkg::CTRL_START];
    wire ones_go = ctrl_wr & ~wdata[csh_pkg::CTRL_START] & wdata[csh_pkg::CTRL_RESET];
    wire ready_fell = ~pin_nxt[0] & pin_r[0];
    // the synced level lags the device's release after a read, so a low level
    // alone would start a second read of the same word
    wire wait_go = (st_r == csh_pkg::H_WAIT) & ready & rdy_seen_r;
    wire chain = last & ((step_r < 3'h3) | (step_r == 3'h5));
    wire sample = last & (step_r == 3'h6);
    wire [15:0] done_inc = done_r + 16'h0001;
    wire finish = sample & (done_inc == tgt_r);
    wire to_wait = last & ((step_r == 3'h3) | (sample & ~finish));
    wire to_idle = last & ((step_r == 3'h7) | finish);
    wire ld = start | ones_go | wait_go | chain;
    wire [2:0] ld_step = start ? 3'h0 : ones_go ? 3'h7 : wait_go ? 3'h5 : step_r + 3'h1;
    wire [7:0] ld_byte =
        (ld_step == 3'h0) ? csh_pkg::CMD_TO_CLOCK :
        (ld_step == 3'h1) ? csh_pkg::CLOCK_WORD :
        (ld_step == 3'h2) ? csh_pkg::CMD_TO_SETUP :
        (ld_step == 3'h3) ? csh_pkg::SETUP_WORD :
        (ld_step == 3'h5) ? csh_pkg::CMD_READ_DATA : 8'hff;
    wire [5:0] ld_len = (ld_step == 3'h6) ? 6'h10 :
        (ld_step == 3'h7) ? 6'(csh_pkg::RESET_ONES) : 6'h08;
    // alternate framing: one active low sync per direction
    wire transmit_frame_sync_n = ~(shifting & ~rdx_r);
    wire receive_frame_sync_n = ~(shifting & rdx_r);
    wire [1:0] irq_set = {finish, sample};
    wire [1:0] irq_clr = (wr && addr == csh_pkg::HR_IRQ) ? wdata[1:0] : 2'h0;
    wire [1:0] irq_nxt = (irq_st_r & ~irq_clr) | irq_set;
    wire [31:0] rmux =
        (addr == csh_pkg::HR_COUNT) ? {16'h0000, tgt_r} :
        (addr == csh_pkg::HR_STATUS) ? {15'h0000, ~(st_r == csh_pkg::H_IDLE), done_r} :
        (addr == csh_pkg::HR_DATA) ? {16'h0000, data_r} :
        (addr == csh_pkg::HR_IRQ) ? {30'h0, irq_st_r} :
        (addr == csh_pkg::HR_MASK) ? {30'h0, mask_r} : 32'h0;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s0_r <= 2'h3;
            s1_r <= 2'h3;
            s2_r <= 2'h3;
            pin_r <= 2'h3;
        end else begin
            s0_r <= {link.miso, link.result_ready_n};
            s1_r <= s0_r;
            s2_r <= s1_r;
            pin_r <= pin_nxt;
        end
    end

    // a fresh fall of the ready line since the last transfer began; set wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdy_seen_r <= 1'b0;
        end else begin
            rdy_seen_r <= ready_fell | (rdy_seen_r & ~ld);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= csh_pkg::H_IDLE;
            step_r <= 3'h0;
            rdx_r <= 1'b0;
        end else if (ld) begin
            st_r <= csh_pkg::H_SHIFT;
            step_r <= ld_step;
            rdx_r <= (ld_step == 3'h6);
        end else if (to_wait) begin
            st_r <= csh_pkg::H_WAIT;
        end else if (to_idle) begin
            st_r <= csh_pkg::H_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_r <= 32'hffffffff;
            rx_r <= 16'h0000;
            len_r <= 6'h08;
            bit_r <= 6'h00;
            div_r <= 8'h00;
            ph_r <= 1'b0;
        end else if (ld) begin
            tx_r <= {ld_byte, 24'hffffff};
            len_r <= ld_len;
            bit_r <= 6'h00;
            div_r <= 8'h00;
            ph_r <= 1'b0;
        end else if (shifting) begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            if (tick) begin
                ph_r <= ~ph_r;
            end
            if (tick && ph_r) begin
                tx_r <= {tx_r[30:0], 1'b1};
                rx_r <= rx_nxt;
                bit_r <= bit_r + 6'h01;
            end
        end
    end

    // clock falls to launch a bit, rises to sample, rests high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sclk_r <= 1'b1;
            mosi_r <= 1'b1;
            cs_n_r <= 1'b1;
        end else begin
            cs_n_r <= transmit_frame_sync_n & receive_frame_sync_n;
            if (!shifting) begin
                sclk_r <= 1'b1;
                mosi_r <= 1'b1;
            end else if (tick) begin
                sclk_r <= ph_r;
                if (!ph_r) begin
                    mosi_r <= tx_r[31];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tgt_r <= 16'h0001;
            done_r <= 16'h0000;
            data_r <= 16'h0000;
            mask_r <= 2'h0;
            irq_st_r <= 2'h0;
            irq_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            if (wr && addr == csh_pkg::HR_COUNT) begin
                tgt_r <= wdata[15:0];
            end
            if (wr && addr == csh_pkg::HR_MASK) begin
                mask_r <= wdata[1:0];
            end
            if (start) begin
                done_r <= 16'h0000;
            end else if (sample) begin
                done_r <= done_inc;
                data_r <= rx_nxt;
            end
            irq_st_r <= irq_nxt;
            irq_r <= |(irq_nxt & mask_r);
            rdata_r <= rd ? rmux : 32'h0;
        end
    end

    assign link.sclk = sclk_r;
    assign link.din = mosi_r;
    assign link.cs_n = cs_n_r;
    assign rdata = rdata_r;
    assign irq = irq_r;
endmodule

// ==== dv/csh_monitor.sv ====
module csh_monitor #(
    parameter int CONV_CYC = 2000,
    parameter int LEAD_CYC = 5
) (
    input logic sys_clk,
    input logic rst,
    input logic sclk,
    input logic din,
    input logic cs_n,
    input logic dout,
    input logic dout_oe,
    input logic result_ready_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // 20 MHz system clock, 3 MHz serial limit: each serial level lasts 4 cycles or more
    localparam int MIN_HALF = 4;
    localparam int LEAD_MIN = LEAD_CYC - 1;
    localparam int LOW_MAX = CONV_CYC - LEAD_CYC + 1;
    logic sclk_d_r;
    int run_r;
    int hi_r;
    int lo_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sclk_d_r <= 1'b1;
            run_r <= 0;
            hi_r <= 0;
            lo_r <= 0;
        end else begin
            sclk_d_r <= sclk;
            run_r <= (sclk != sclk_d_r) ? 1 : ((run_r < 1000) ? run_r + 1 : run_r);
            hi_r <= result_ready_n ? hi_r + 1 : 0;
            lo_r <= result_ready_n ? 0 : lo_r + 1;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_sclk_idle_high: assert property (cs_n |-> sclk)
        else $error("serial clock low while deselected");
    a_sclk_rate: assert property ((sclk != sclk_d_r) |-> run_r >= MIN_HALF)
        else $error("serial clock level too short");
    a_oe_release: assert property ($rose(cs_n) |-> ##[0:6] !dout_oe)
        else $error("device still drives after deselect");
    a_oe_after_cmd: assert property ($rose(dout_oe) |-> sclk && !cs_n)
        else $error("drive started outside a selected frame");
    a_dout_steady: assert property (dout_oe && $past(dout_oe) && sclk |-> $stable(dout))
        else $error("output bit moved while clock high");
    a_ready_on_read: assert property ($fell(dout_oe) |-> ##[0:6] result_ready_n)
        else $error("ready line not released after data read");
    a_ready_lead: assert property ($fell(result_ready_n) |-> hi_r >= LEAD_MIN)
        else $error("ready line fell without lead time");
    a_ready_low_max: assert property (!result_ready_n |-> lo_r <= LOW_MAX)
        else $error("ready line low past the update point");

    c_data_read: cover property ($fell(dout_oe));
    c_ready_fall: cover property ($fell(result_ready_n));
    c_frame_zero: cover property (!cs_n && !din);
endmodule

// ==== dv/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CONV = 2000;
    localparam int LEAD = 5;
    localparam int HALF = 10;
    logic sys_clk;
    logic rst;
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic irq;
    logic [15:0] conv_word;
    logic conv_take;
    logic cal1, cal3, sclk_q, rrn3_q;
    logic [7:0] setup1, clock1, setup3, clock3, wbuf;
    logic [1:0] chan1, chan3;
    logic [15:0] rbuf, last_word, last_rd;
    logic fresh = 1'b0;
    int err_total = 0, n_checks = 0, seed = 32'hb1f530b9;
    int widx = 0, wbits = 0, rbits = 0, n_reads = 0, ncal1 = 0, ncal3 = 0, nfall3 = 0;

    csh_if if1 ();
    csh_if if3 ();
    // second device listens to the same wires with its select tied low
    assign if3.sclk = if1.sclk;
    assign if3.din = if1.din;
    assign if3.cs_n = 1'b0;

    csh_host #(.HALF_CYC(HALF)) csh_host_inst (.sys_clk(sys_clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .link(if1.host));
    csh_dev #(.CONV_CYC(CONV), .LEAD_CYC(LEAD)) csh_dev_inst (.sys_clk(sys_clk), .rst(rst),
        .link(if1.dev), .conv_word(conv_word), .conv_take(conv_take), .cal_start(cal1),
        .setup_q(setup1), .clock_q(clock1), .chan_q(chan1));
    csh_dev #(.CONV_CYC(CONV), .LEAD_CYC(LEAD)) csh_dev_inst_3w (.sys_clk(sys_clk), .rst(rst),
        .link(if3.dev), .conv_word(conv_word), .conv_take(), .cal_start(cal3),
        .setup_q(setup3), .clock_q(clock3), .chan_q(chan3));
    csh_monitor #(.CONV_CYC(CONV), .LEAD_CYC(LEAD)) csh_monitor_inst (.sys_clk(sys_clk),
        .rst(rst), .sclk(if1.sclk), .din(if1.din), .cs_n(if1.cs_n), .dout(if1.dout),
        .dout_oe(if1.dout_oe), .result_ready_n(if1.result_ready_n));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] exp_byte(input int i);
        case (i)
            0: return {1'b0, csh_pkg::RS_CLOCK, 4'h0};
            1: return csh_pkg::CLOCK_WORD;
            2: return {1'b0, csh_pkg::RS_SETUP, 4'h0};
            3: return csh_pkg::SETUP_WORD;
            default: return {1'b0, csh_pkg::RS_DATA, 4'h8};
        endcase
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string name);
        logic [31:0] v;
        rd_reg(a, v);
        chk(name, exp, v);
    endtask

    task automatic run_seq(input int cnt);
        logic [31:0] v;
        int n;
        wr_reg(csh_pkg::HR_COUNT, 32'(cnt));
        wr_reg(csh_pkg::HR_MASK, 32'h1);
        widx = 0;
        wbits = 0;
        n_reads = 0;
        ncal1 = 0;
        ncal3 = 0;
        wr_reg(csh_pkg::HR_CTRL, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("irq_raised", 32'h1, 32'(irq));
        wr_reg(csh_pkg::HR_IRQ, 32'h1);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("irq_cleared", 32'h0, 32'(irq));
        rd_reg(csh_pkg::HR_STATUS, v);
        while (v[16] !== 1'b0 && n < 40000) begin
            n++;
            rd_reg(csh_pkg::HR_STATUS, v);
        end
        chk("done_count", 32'(cnt), v);
        chk("reads", 32'(cnt), 32'(n_reads));
        chk("bytes", 32'(4 + cnt), 32'(widx));
        rd_chk(csh_pkg::HR_IRQ, 32'h3, "irq_done");
        rd_chk(csh_pkg::HR_DATA, 32'(last_rd), "data_reg");
        wr_reg(csh_pkg::HR_IRQ, 32'h3);
        wr_reg(csh_pkg::HR_MASK, 32'h0);
        chk("cal_start", 32'h1, 32'(ncal1));
        chk("setup", 32'(csh_pkg::SETUP_WORD), 32'(setup1));
        chk("clock", 32'(csh_pkg::CLOCK_WORD), 32'(clock1));
        chk("halve", 32'h1, 32'(clock1[csh_pkg::CLOCK_HALVE_BIT]));
        chk("chan", 32'h0, 32'(chan1));
        chk("setup_3w", 32'(csh_pkg::SETUP_WORD), 32'(setup3));
        chk("clock_3w", 32'(csh_pkg::CLOCK_WORD), 32'(clock3));
        chk("cal_3w", 32'h1, 32'(ncal3));
        chk("ready_3w", 32'h1, 32'(nfall3 > 0));
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("irq_off", 32'h0, 32'(irq));
    endtask

    // serial observer: rebuilds words on host sampling edges
    always @(posedge sys_clk) begin
        sclk_q <= if1.sclk;
        rrn3_q <= if3.result_ready_n;
        if (conv_take) begin
            last_word = conv_word;
            fresh = 1'b1;
            conv_word <= 16'($random(seed));
        end
        if (cal1) ncal1++;
        if (cal3) ncal3++;
        if (rrn3_q && !if3.result_ready_n) nfall3++;
        if (!rst && if1.sclk && !sclk_q && !if1.cs_n) begin
            if (if1.dout_oe) begin
                rbuf = {rbuf[14:0], if1.miso};
                rbits++;
                if (rbits == 16) begin
                    chk("read_word", 32'(last_word), 32'(rbuf));
                    chk("read_fresh", 32'h1, 32'(fresh));
                    fresh = 1'b0;
                    last_rd = rbuf;
                    n_reads++;
                    rbits = 0;
                end
            end else begin
                wbuf = {wbuf[6:0], if1.din};
                wbits++;
                // all-ones bytes belong to the interface recovery run
                if (wbits == 8 && wbuf != 8'hff) begin
                    chk("cmd_byte", 32'(exp_byte(widx)), 32'(wbuf));
                    widx++;
                end
                if (wbits == 8) wbits = 0;
            end
        end
    end

    initial begin
        rst = 1'b1;
        addr = 5'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        conv_word = 16'($random(seed));
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(csh_pkg::HR_STATUS, 32'h0, "status_rst");
        rd_chk(csh_pkg::HR_COUNT, 32'h1, "count_rst");
        rd_chk(csh_pkg::HR_CTRL, 32'h0, "ctrl_read");
        wr_reg(5'h1c, 32'h5a5a);
        rd_chk(5'h1c, 32'h0, "unmapped");
        chk("setup_rst", 32'(csh_pkg::SETUP_RST), 32'(setup1));
        chk("clock_rst", 32'(csh_pkg::CLOCK_RST), 32'(clock1));
        run_seq(2 + ($random(seed) & 3));
        wr_reg(csh_pkg::HR_CTRL, 32'h2);
        repeat (64 * HALF + 200) @(posedge sys_clk);
        chk("setup_kept", 32'(csh_pkg::SETUP_WORD), 32'(setup1));
        chk("clock_kept", 32'(csh_pkg::CLOCK_WORD), 32'(clock1));
        run_seq(2 + ($random(seed) & 3));
        print_verdict();
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end
endmodule
